/* logic/bsr_pkg.sv */
// Shared constants and types for the bridge converter serial readout block.
// Assumes a 50 MHz system clock; converter timing is counted in modulator clock ticks.
package bsr_pkg;

  localparam longint unsigned REF_HZ = 50_000_000;
  localparam longint unsigned MOD_HZ = 4_915_200;
  localparam longint unsigned NS_PER_S = 1_000_000_000;

  // Least times round up to whole cycles.
  function automatic longint unsigned bsr_ceil_div(input longint unsigned n, input longint unsigned d);
    return (n + d - 1) / d;
  endfunction : bsr_ceil_div

  localparam int TICK_W = 22;
  typedef logic [TICK_W-1:0] bsr_tick_t;

  // Conversion period in modulator ticks, internal or external clock alike.
  localparam longint unsigned CONV_HI_DIV = 61_440;
  localparam longint unsigned CONV_LO_DIV = 491_520;

  localparam longint unsigned UPDATE_WINDOW_NS = 39_000;
  localparam longint unsigned CAL_HI_NS = 101_280_000;
  localparam longint unsigned CAL_LO_NS = 801_020_000;
  localparam longint unsigned WAKE_DATA_HI_NS = 52_510_000;
  localparam longint unsigned WAKE_DATA_LO_NS = 401_800_000;
  localparam longint unsigned WAKE_CAL_HI_NS = 103_000_000;
  localparam longint unsigned WAKE_CAL_LO_NS = 803_000_000;
  localparam longint unsigned STANDBY_ACT_NS = 20_000;
  localparam longint unsigned CLK_DETECT_NS = 5_000;

  localparam bsr_tick_t UPDATE_TICKS = bsr_tick_t'(bsr_ceil_div(UPDATE_WINDOW_NS * MOD_HZ, NS_PER_S));
  localparam bsr_tick_t CONV_HI_TICKS = bsr_tick_t'(CONV_HI_DIV);
  localparam bsr_tick_t CONV_LO_TICKS = bsr_tick_t'(CONV_LO_DIV);
  localparam bsr_tick_t CAL_HI_TICKS = bsr_tick_t'(bsr_ceil_div(CAL_HI_NS * MOD_HZ, NS_PER_S));
  localparam bsr_tick_t CAL_LO_TICKS = bsr_tick_t'(bsr_ceil_div(CAL_LO_NS * MOD_HZ, NS_PER_S));
  localparam bsr_tick_t WAKE_DATA_HI_TICKS = bsr_tick_t'(bsr_ceil_div(WAKE_DATA_HI_NS * MOD_HZ, NS_PER_S));
  localparam bsr_tick_t WAKE_DATA_LO_TICKS = bsr_tick_t'(bsr_ceil_div(WAKE_DATA_LO_NS * MOD_HZ, NS_PER_S));
  localparam bsr_tick_t WAKE_CAL_HI_TICKS = bsr_tick_t'(bsr_ceil_div(WAKE_CAL_HI_NS * MOD_HZ, NS_PER_S));
  localparam bsr_tick_t WAKE_CAL_LO_TICKS = bsr_tick_t'(bsr_ceil_div(WAKE_CAL_LO_NS * MOD_HZ, NS_PER_S));

  localparam logic [10:0] STANDBY_CYCLES = 11'(bsr_ceil_div(STANDBY_ACT_NS * REF_HZ, NS_PER_S));
  localparam logic [8:0] CLK_DETECT_CYCLES = 9'(CLK_DETECT_NS * REF_HZ / NS_PER_S);
  localparam logic [22:0] NCO_STEP = 23'(MOD_HZ);
  localparam logic [26:0] NCO_WRAP = 27'(REF_HZ);

  // Result layout and shift-clock pulse numbers.
  localparam int RESULT_W = 20;
  localparam int RAW_W = 24;
  localparam logic [4:0] DATA_PULSES = 5'h14;
  localparam logic [4:0] CAL_WAKE_PULSES = 5'h19;
  localparam logic [4:0] CAL_PULSES = 5'h1a;
  localparam logic [4:0] PULSE_MAX = 5'h1f;
  localparam logic [RESULT_W-1:0] RESULT_RESET = 20'h00000;

  typedef enum logic [1:0] {
    BSR_CONVERT,
    BSR_CALIBRATE,
    BSR_STANDBY,
    BSR_WAKE
  } bsr_state_e;

  typedef struct packed {
    logic analog_power_en;
    logic inputs_connect;
    logic cal_signal_en;
  } bsr_analog_s;

endpackage : bsr_pkg

/* logic/bsr_timebase.sv */
// Modulator clock tick source for the serial readout block.
// Assumes ext_clock_in is a plain input sampled on ref_clk_in and well below half its rate.
`timescale 1ns/1ns
`default_nettype none

module bsr_timebase (
  input wire logic ref_clk_in,
  input wire logic arst_n_in,
  input wire logic ext_clock_in,
  output logic tick_out,
  output logic ext_sel_out
);

  logic ext_s1_reg;
  logic ext_s2_reg;
  logic ext_s3_reg;
  logic ext_edge;
  logic [8:0] quiet_reg;
  logic [26:0] acc_reg;
  logic [26:0] acc_next;
  logic nco_tick;

  always_ff @(posedge ref_clk_in or negedge arst_n_in) begin
    if (!arst_n_in) begin
      ext_s1_reg <= 1'b0;
      ext_s2_reg <= 1'b0;
      ext_s3_reg <= 1'b0;
    end else begin
      ext_s1_reg <= ext_clock_in;
      ext_s2_reg <= ext_s1_reg;
      ext_s3_reg <= ext_s2_reg;
    end
  end

  assign ext_edge = ext_s2_reg && !ext_s3_reg;

  // A pin that stays quiet longer than the detect time falls back to the internal source.
  always_ff @(posedge ref_clk_in or negedge arst_n_in) begin
    if (!arst_n_in) begin
      quiet_reg <= bsr_pkg::CLK_DETECT_CYCLES;
      ext_sel_out <= 1'b0;
    end else if (ext_edge) begin
      quiet_reg <= 9'h000;
      ext_sel_out <= 1'b1;
    end else if (quiet_reg < bsr_pkg::CLK_DETECT_CYCLES) begin
      quiet_reg <= quiet_reg + 9'h001;
    end else begin
      ext_sel_out <= 1'b0;
    end
  end

  // Exact fractional divider: the average tick rate equals the nominal modulator clock.
  always_comb begin
    acc_next = acc_reg + 27'(bsr_pkg::NCO_STEP);
    nco_tick = 1'b0;
    if (acc_next >= bsr_pkg::NCO_WRAP) begin
      acc_next = acc_next - bsr_pkg::NCO_WRAP;
      nco_tick = 1'b1;
    end
  end

  always_ff @(posedge ref_clk_in or negedge arst_n_in) begin
    if (!arst_n_in) begin
      acc_reg <= 27'h0000000;
    end else begin
      acc_reg <= acc_next;
    end
  end

  assign tick_out = ext_sel_out ? ext_edge : nco_tick;

endmodule : bsr_timebase

`default_nettype wire

/* logic/bsr_readout.sv */
// Readout and control logic of a 20-bit delta-sigma converter with a shared ready/data pin.
// Assumes rate select, power-down and filter value are synchronous to ref_clk_in; the shift clock is resynchronised here.
`timescale 1ns/1ns
`default_nettype none

module bsr_readout #(
  parameter bsr_pkg::bsr_tick_t CONV_HI_TICKS = bsr_pkg::CONV_HI_TICKS,
  parameter bsr_pkg::bsr_tick_t CONV_LO_TICKS = bsr_pkg::CONV_LO_TICKS,
  parameter bsr_pkg::bsr_tick_t CAL_HI_TICKS = bsr_pkg::CAL_HI_TICKS,
  parameter bsr_pkg::bsr_tick_t CAL_LO_TICKS = bsr_pkg::CAL_LO_TICKS,
  parameter bsr_pkg::bsr_tick_t WAKE_DATA_HI_TICKS = bsr_pkg::WAKE_DATA_HI_TICKS,
  parameter bsr_pkg::bsr_tick_t WAKE_DATA_LO_TICKS = bsr_pkg::WAKE_DATA_LO_TICKS,
  parameter bsr_pkg::bsr_tick_t WAKE_CAL_HI_TICKS = bsr_pkg::WAKE_CAL_HI_TICKS,
  parameter bsr_pkg::bsr_tick_t WAKE_CAL_LO_TICKS = bsr_pkg::WAKE_CAL_LO_TICKS
) (
  input wire logic ref_clk_in,
  input wire logic arst_n_in,
  input wire logic power_down_n,
  input wire logic rate_sel_in,
  input wire logic ext_clock_in,
  input wire logic shift_clk_in,
  input wire logic signed [bsr_pkg::RAW_W-1:0] filter_value_in,
  output logic ready_data_out,
  output bsr_pkg::bsr_analog_s analog_ctrl_out,
  output logic ext_clock_active_out
);

  bsr_pkg::bsr_state_e state_reg;
  bsr_pkg::bsr_tick_t cnt_reg;
  bsr_pkg::bsr_tick_t wait_reg;
  bsr_pkg::bsr_tick_t limit;
  bsr_pkg::bsr_tick_t conv_ticks;
  logic [bsr_pkg::RESULT_W-1:0] result_reg;
  logic [4:0] pulse_reg;
  logic armed_reg;
  logic cal_on_wake_reg;
  logic [10:0] high_reg;
  logic sclk_s1_reg;
  logic sclk_s2_reg;
  logic sclk_s3_reg;
  logic sclk_rise;
  logic sclk_fall;
  logic tick;
  logic ready_evt;
  logic update_evt;
  logic cal_start;
  logic stby_enter;
  logic wake_evt;

  // Clip the wider filter word to the 20-bit full-scale codes.
  function automatic logic [bsr_pkg::RESULT_W-1:0] clip_result(input logic signed [bsr_pkg::RAW_W-1:0] v);
    if (v > 24'sh07ffff) begin
      return 20'h7ffff;
    end else if (v < 24'shf80000) begin
      return 20'h80000;
    end else begin
      return v[bsr_pkg::RESULT_W-1:0];
    end
  endfunction : clip_result

  bsr_timebase u_timebase (
    .ref_clk_in(ref_clk_in),
    .arst_n_in(arst_n_in),
    .ext_clock_in(ext_clock_in),
    .tick_out(tick),
    .ext_sel_out(ext_clock_active_out)
  );

  // The first stage feeds only the second; edges are taken between later stages.
  always_ff @(posedge ref_clk_in or negedge arst_n_in) begin
    if (!arst_n_in) begin
      sclk_s1_reg <= 1'b0;
      sclk_s2_reg <= 1'b0;
      sclk_s3_reg <= 1'b0;
    end else begin
      sclk_s1_reg <= shift_clk_in;
      sclk_s2_reg <= sclk_s1_reg;
      sclk_s3_reg <= sclk_s2_reg;
    end
  end

  assign sclk_rise = sclk_s2_reg && !sclk_s3_reg;
  assign sclk_fall = !sclk_s2_reg && sclk_s3_reg;

  // High-time counter for standby entry; saturates once the activation time is met.
  always_ff @(posedge ref_clk_in or negedge arst_n_in) begin
    if (!arst_n_in) begin
      high_reg <= 11'h000;
    end else if (!power_down_n || !sclk_s2_reg) begin
      high_reg <= 11'h000;
    end else if (high_reg < bsr_pkg::STANDBY_CYCLES) begin
      high_reg <= high_reg + 11'h001;
    end
  end

  assign conv_ticks = rate_sel_in ? CONV_HI_TICKS : CONV_LO_TICKS;
  assign limit = (state_reg == bsr_pkg::BSR_CONVERT) ? conv_ticks : wait_reg;

  always_comb begin
    ready_evt = 1'b0;
    update_evt = 1'b0;
    cal_start = 1'b0;
    stby_enter = 1'b0;
    wake_evt = 1'b0;
    case (state_reg)
      bsr_pkg::BSR_CONVERT: begin
        stby_enter = (high_reg == bsr_pkg::STANDBY_CYCLES - 11'h001) && sclk_s2_reg;
        cal_start = !stby_enter && sclk_fall && (pulse_reg == bsr_pkg::CAL_PULSES);
        ready_evt = !stby_enter && !cal_start && tick && (cnt_reg >= limit - 22'h000001);
        update_evt = tick && (cnt_reg == limit - bsr_pkg::UPDATE_TICKS);
      end
      bsr_pkg::BSR_CALIBRATE: begin
        ready_evt = tick && (cnt_reg >= limit - 22'h000001);
      end
      bsr_pkg::BSR_STANDBY: begin
        wake_evt = sclk_fall;
      end
      bsr_pkg::BSR_WAKE: begin
        ready_evt = tick && (cnt_reg >= limit - 22'h000001);
      end
      default: begin
        ready_evt = 1'b0;
      end
    endcase
  end

  // Sequencing of conversion, calibration, standby and wake-up.
  always_ff @(posedge ref_clk_in or negedge arst_n_in) begin
    if (!arst_n_in) begin
      state_reg <= bsr_pkg::BSR_CONVERT;
      cnt_reg <= '0;
      wait_reg <= '0;
      cal_on_wake_reg <= 1'b0;
    end else if (!power_down_n) begin
      state_reg <= bsr_pkg::BSR_CONVERT;
      cnt_reg <= '0;
      wait_reg <= '0;
      cal_on_wake_reg <= 1'b0;
    end else begin
      case (state_reg)
        bsr_pkg::BSR_CONVERT: begin
          if (stby_enter) begin
            state_reg <= bsr_pkg::BSR_STANDBY;
            // The rise that starts the hold is counted as well, so 25 full pulses read one more here.
            cal_on_wake_reg <= (pulse_reg == bsr_pkg::CAL_WAKE_PULSES + 5'h01);
            cnt_reg <= '0;
          end else if (cal_start) begin
            state_reg <= bsr_pkg::BSR_CALIBRATE;
            wait_reg <= rate_sel_in ? CAL_HI_TICKS : CAL_LO_TICKS;
            cnt_reg <= '0;
          end else if (ready_evt) begin
            cnt_reg <= '0;
          end else if (tick) begin
            cnt_reg <= cnt_reg + 22'h000001;
          end
        end
        bsr_pkg::BSR_STANDBY: begin
          if (wake_evt) begin
            state_reg <= bsr_pkg::BSR_WAKE;
            if (cal_on_wake_reg) begin
              wait_reg <= rate_sel_in ? WAKE_CAL_HI_TICKS : WAKE_CAL_LO_TICKS;
            end else begin
              wait_reg <= rate_sel_in ? WAKE_DATA_HI_TICKS : WAKE_DATA_LO_TICKS;
            end
            cnt_reg <= '0;
          end
        end
        bsr_pkg::BSR_CALIBRATE, bsr_pkg::BSR_WAKE: begin
          if (ready_evt) begin
            state_reg <= bsr_pkg::BSR_CONVERT;
            cal_on_wake_reg <= 1'b0;
            cnt_reg <= '0;
          end else if (tick) begin
            cnt_reg <= cnt_reg + 22'h000001;
          end
        end
        default: begin
          state_reg <= bsr_pkg::BSR_CONVERT;
        end
      endcase
    end
  end

  // New result capture; an unread word is simply replaced.
  always_ff @(posedge ref_clk_in or negedge arst_n_in) begin
    if (!arst_n_in) begin
      result_reg <= bsr_pkg::RESULT_RESET;
    end else if (!power_down_n) begin
      result_reg <= bsr_pkg::RESULT_RESET;
    end else if (ready_evt) begin
      result_reg <= clip_result(filter_value_in);
    end
  end

  // Shared pin and pulse counting; a pulse on the same edge as ready is dropped and counts for neither word.
  always_ff @(posedge ref_clk_in or negedge arst_n_in) begin
    if (!arst_n_in) begin
      ready_data_out <= 1'b1;
      pulse_reg <= 5'h00;
      armed_reg <= 1'b0;
    end else if (!power_down_n) begin
      ready_data_out <= 1'b1;
      pulse_reg <= 5'h00;
      armed_reg <= 1'b0;
    end else if (ready_evt) begin
      ready_data_out <= 1'b0;
      pulse_reg <= 5'h00;
      armed_reg <= 1'b1;
    end else if (stby_enter || cal_start || state_reg != bsr_pkg::BSR_CONVERT) begin
      ready_data_out <= 1'b1;
      armed_reg <= 1'b0;
    end else if (update_evt) begin
      ready_data_out <= 1'b1;
      armed_reg <= 1'b0;
    end else if (sclk_rise) begin
      if (pulse_reg != bsr_pkg::PULSE_MAX) begin
        pulse_reg <= pulse_reg + 5'h01;
      end
      if (armed_reg && pulse_reg < bsr_pkg::DATA_PULSES) begin
        ready_data_out <= result_reg[5'(bsr_pkg::RESULT_W - 1) - pulse_reg];
      end else begin
        ready_data_out <= 1'b1;
      end
    end
  end

  always_comb begin
    analog_ctrl_out.analog_power_en = (state_reg != bsr_pkg::BSR_STANDBY);
    analog_ctrl_out.inputs_connect = (state_reg != bsr_pkg::BSR_CALIBRATE);
    analog_ctrl_out.cal_signal_en = (state_reg == bsr_pkg::BSR_CALIBRATE);
  end

  default clocking cb @(posedge ref_clk_in);
  endclocking
  default disable iff (!arst_n_in);

  property p_ready_low;
    ready_evt && power_down_n |=> !ready_data_out;
  endproperty
  a_ready_low: assert property (p_ready_low) else $error("ready did not fall on new result");

  property p_bit_out;
    power_down_n && sclk_rise && armed_reg && pulse_reg < 5'h14 && !ready_evt && !update_evt
      && state_reg == bsr_pkg::BSR_CONVERT && !stby_enter && !cal_start
      |=> ready_data_out == result_reg[5'd19 - $past(pulse_reg)];
  endproperty
  a_bit_out: assert property (p_bit_out) else $error("wrong data bit shifted out");

  property p_ones_tail;
    power_down_n && sclk_rise && pulse_reg >= 5'h14 && !ready_evt |=> ready_data_out;
  endproperty
  a_ones_tail: assert property (p_ones_tail) else $error("tail pulse did not drive one");

  property p_cal_enter;
    power_down_n && cal_start |=> state_reg == bsr_pkg::BSR_CALIBRATE && analog_ctrl_out.cal_signal_en
      && !analog_ctrl_out.inputs_connect && ready_data_out;
  endproperty
  a_cal_enter: assert property (p_cal_enter) else $error("calibration not entered");

  property p_standby_quiet;
    state_reg == bsr_pkg::BSR_STANDBY |-> ready_data_out && !analog_ctrl_out.analog_power_en;
  endproperty
  a_standby_quiet: assert property (p_standby_quiet) else $error("standby output not quiet");

  property p_standby_enter;
    power_down_n && state_reg == bsr_pkg::BSR_CONVERT && high_reg == 11'd999 && sclk_s2_reg
      |=> state_reg == bsr_pkg::BSR_STANDBY;
  endproperty
  a_standby_enter: assert property (p_standby_enter) else $error("standby not entered after hold");

  property p_clip_high;
    ready_evt && power_down_n && filter_value_in > 24'sh07ffff |=> result_reg == 20'h7ffff;
  endproperty
  a_clip_high: assert property (p_clip_high) else $error("positive overrange not clipped");

  property p_power_down;
    !power_down_n |=> state_reg == bsr_pkg::BSR_CONVERT && ready_data_out && pulse_reg == 5'h00;
  endproperty
  a_power_down: assert property (p_power_down) else $error("power-down did not reset");

  property p_wake;
    power_down_n && state_reg == bsr_pkg::BSR_STANDBY && sclk_fall |=> state_reg == bsr_pkg::BSR_WAKE
      ##0 (wait_reg == ($past(cal_on_wake_reg) ? ($past(rate_sel_in) ? WAKE_CAL_HI_TICKS : WAKE_CAL_LO_TICKS)
      : ($past(rate_sel_in) ? WAKE_DATA_HI_TICKS : WAKE_DATA_LO_TICKS)));
  endproperty
  a_wake: assert property (p_wake) else $error("wake-up delay not loaded");

endmodule : bsr_readout

`default_nettype wire

/* tb/bsr_host.sv */
// Host model: drives the shift clock and collects bits from the shared ready/data pin.
// Assumes the bench calls its tasks from one process; the clock idles low between frames.
`timescale 1ns/1ns
`default_nettype none

module bsr_host (
  input wire logic ref_clk_in,
  input wire logic ready_data_in,
  output logic shift_clk_out,
  output logic word_valid_out,
  output logic [23:0] word_out
);
  initial begin
    shift_clk_out = 1'b0;
    word_valid_out = 1'b0;
    word_out = 24'h000000;
  end

  // Each bit is taken just before the fall, so slow pulses still see the settled answer.
  task automatic shift(input int n, input int half, input logic report);
    logic [23:0] w;
    w = 24'h000000;
    for (int i = 0; i < n; i++) begin
      repeat (half) @(negedge ref_clk_in);
      shift_clk_out = 1'b1;
      repeat (half) @(negedge ref_clk_in);
      w = {w[22:0], ready_data_in};
      shift_clk_out = 1'b0;
    end
    if (report) begin
      word_out = w;
      word_valid_out = 1'b1;
      @(negedge ref_clk_in);
      word_valid_out = 1'b0;
    end
  endtask : shift

  // Holding the clock high parks the device in standby; lowering it wakes the device.
  // Five cycles keep the previous level for at least the minimum pulse width.
  task automatic set_clk(input logic level);
    repeat (5) @(negedge ref_clk_in);
    shift_clk_out = level;
  endtask : set_clk
endmodule : bsr_host
`default_nettype wire

/* tb/bsr_readout_tb.sv */
// Self-checking bench for the serial readout block with a behavioural host on the shift clock.
// Assumes shortened tick counts; the external clock gives one tick per ten reference cycles.
`timescale 1ns/1ns
`default_nettype none

module bsr_readout_tb;
  localparam bsr_pkg::bsr_tick_t CONV_HI = 22'h00012c;
  localparam bsr_pkg::bsr_tick_t CONV_LO = 22'h000258;
  localparam bsr_pkg::bsr_tick_t CAL_T = 22'h000190;
  localparam bsr_pkg::bsr_tick_t WAKE_T = 22'h0000fa;
  localparam bsr_pkg::bsr_tick_t WAKE_CAL_T = 22'h0001f4;
  localparam int EXT_CYC = 10;
  localparam int LIMIT = 90000;

  logic ref_clk_in, arst_n_in, power_down_n, rate_sel_in, ext_clock_in, shift_clk, ready_data_out;
  logic ext_clock_active_out, word_valid, ext_en;
  logic signed [23:0] filter_value_in;
  logic signed [23:0] vals [5];
  logic [23:0] host_word;
  logic [23:0] exp_q[$];
  bsr_pkg::bsr_analog_s analog_ctrl_out;
  int mismatches = 0, samples_checked = 0, cycles = 0, t0, t1, nom;

  bsr_readout #(.CONV_HI_TICKS(CONV_HI), .CONV_LO_TICKS(CONV_LO), .CAL_HI_TICKS(CAL_T),
    .CAL_LO_TICKS(CAL_T), .WAKE_DATA_HI_TICKS(WAKE_T), .WAKE_DATA_LO_TICKS(WAKE_T),
    .WAKE_CAL_HI_TICKS(WAKE_CAL_T), .WAKE_CAL_LO_TICKS(WAKE_CAL_T)) DUT (
    .ref_clk_in(ref_clk_in), .arst_n_in(arst_n_in), .power_down_n(power_down_n),
    .rate_sel_in(rate_sel_in), .ext_clock_in(ext_clock_in), .shift_clk_in(shift_clk),
    .filter_value_in(filter_value_in), .ready_data_out(ready_data_out),
    .analog_ctrl_out(analog_ctrl_out), .ext_clock_active_out(ext_clock_active_out));

  bsr_host u_host (.ref_clk_in(ref_clk_in), .ready_data_in(ready_data_out), .shift_clk_out(shift_clk),
    .word_valid_out(word_valid), .word_out(host_word));

  initial begin
    ref_clk_in = 1'b0;
    forever #10 ref_clk_in = ~ref_clk_in;
  end

  // Toggling on falling reference edges keeps the external tick period an exact cycle count.
  initial begin
    ext_clock_in = 1'b0;
    forever begin
      #100;
      ext_clock_in = ext_en & ~ext_clock_in;
    end
  end

  always @(posedge ref_clk_in) begin
    cycles <= cycles + 1;
    if (cycles == LIMIT) begin
      mismatches++;
      end_of_test();
    end
  end

  always @(posedge ref_clk_in) begin
    if (word_valid === 1'b1) begin
      check_word("read word", exp_q.size() > 0 ? exp_q.pop_front() : 24'hxxxxxx, host_word);
    end
  end

  function automatic logic [19:0] clip(input logic signed [23:0] v);
    if (v > 24'sh07ffff) return 20'h7ffff;
    if (v < 24'shf80000) return 20'h80000;
    return v[19:0];
  endfunction : clip

  task automatic check_word(input string what, input logic [23:0] e, input logic [23:0] seen);
    samples_checked++;
    if (seen !== e) begin
      mismatches++;
      $display("mismatch %s expected %h seen %h", what, e, seen);
    end
  endtask : check_word

  task automatic check_bit(input string what, input logic e, input logic seen);
    samples_checked++;
    if (seen !== e) begin
      mismatches++;
      $display("mismatch %s expected %b seen %b", what, e, seen);
    end
  endtask : check_bit

  task automatic check_time(input string what, input int lo, input int hi, input int seen);
    samples_checked++;
    if (seen < lo || seen > hi) begin
      mismatches++;
      $display("mismatch %s expected %0d..%0d seen %0d", what, lo, hi, seen);
    end
  endtask : check_time

  task automatic wait_fall(output int at);
    while (ready_data_out !== 1'b1 && cycles < LIMIT) @(negedge ref_clk_in);
    while (ready_data_out !== 1'b0 && cycles < LIMIT) @(negedge ref_clk_in);
    at = cycles;
  endtask : wait_fall

  // The filter word is left alone until the read, so it is the value captured at the ready event.
  task automatic read_value(input int n);
    exp_q.push_back({clip(filter_value_in), 4'hf} >> (24 - n));
    u_host.shift(n, $urandom_range(12, 5), 1'b1);
  endtask : read_value

  task automatic end_of_test();
    if (exp_q.size() != 0) mismatches++;
    $display("checks %0d mismatches %0d", samples_checked, mismatches);
    if (mismatches == 0 && samples_checked > 0) begin
      $display("Test passed");
    end else begin
      $display("Test failed");
    end
    $finish;
  endtask : end_of_test

  initial begin
    void'($urandom(26));
    arst_n_in = 1'b0;
    power_down_n = 1'b1;
    rate_sel_in = 1'b1;
    filter_value_in = 24'sh000000;
    ext_en = 1'b0;
    vals = '{24'sh080000, 24'shf7ffff, 24'sh000001, 24'shffffff, 24'sh000000};
    vals[4] = 24'($urandom);
    repeat (16) @(negedge ref_clk_in);
    arst_n_in = 1'b1;
    check_bit("idle pin", 1'b1, ready_data_out);
    check_bit("analog power", 1'b1, analog_ctrl_out.analog_power_en);
    check_bit("ext select", 1'b0, ext_clock_active_out);
    wait_fall(t0);
    wait_fall(t1);
    nom = int'((longint'(CONV_HI) * bsr_pkg::REF_HZ) / bsr_pkg::MOD_HZ);
    check_time("internal period", nom - 12, nom + 12, t1 - t0);
    ext_en = 1'b1;
    repeat (300) @(negedge ref_clk_in);
    check_bit("ext select", 1'b1, ext_clock_active_out);
    filter_value_in = 24'sh123456;
    wait_fall(t0);
    filter_value_in = 24'sh03c5a6;
    wait_fall(t1);
    check_time("ext period", int'(CONV_HI) * EXT_CYC - 2, int'(CONV_HI) * EXT_CYC + 2, t1 - t0);
    read_value(24);
    foreach (vals[i]) begin
      filter_value_in = vals[i];
      wait_fall(t0);
      read_value(24);
      check_bit("pin after 24", 1'b1, ready_data_out);
    end
    filter_value_in = 24'sh000002;
    wait_fall(t0);
    read_value(20);
    repeat (30) @(negedge ref_clk_in);
    check_bit("held last bit", 1'b0, ready_data_out);
    filter_value_in = 24'shfedcba;
    wait_fall(t0);
    read_value(24);
    u_host.shift(2, 5, 1'b0);
    t0 = cycles;
    repeat (20) @(negedge ref_clk_in);
    check_bit("inputs in cal", 1'b0, analog_ctrl_out.inputs_connect);
    check_bit("cal signal", 1'b1, analog_ctrl_out.cal_signal_en);
    check_bit("pin in cal", 1'b1, ready_data_out);
    wait_fall(t1);
    check_time("cal time", int'(CAL_T) * EXT_CYC - 8, int'(CAL_T) * EXT_CYC + 8, t1 - t0);
    read_value(24);
    wait_fall(t0);
    read_value(5);
    u_host.set_clk(1'b1);
    repeat (900) @(negedge ref_clk_in);
    check_bit("power early", 1'b1, analog_ctrl_out.analog_power_en);
    repeat (200) @(negedge ref_clk_in);
    check_bit("power standby", 1'b0, analog_ctrl_out.analog_power_en);
    check_bit("pin standby", 1'b1, ready_data_out);
    u_host.set_clk(1'b0);
    t0 = cycles;
    wait_fall(t1);
    check_time("wake time", int'(WAKE_T) * EXT_CYC - 8, int'(WAKE_T) * EXT_CYC + 8, t1 - t0);
    read_value(24);
    u_host.shift(1, 5, 1'b0);
    u_host.set_clk(1'b1);
    repeat (1100) @(negedge ref_clk_in);
    check_bit("power standby", 1'b0, analog_ctrl_out.analog_power_en);
    u_host.set_clk(1'b0);
    t0 = cycles;
    wait_fall(t1);
    check_time("wake cal", int'(WAKE_CAL_T) * EXT_CYC - 8, int'(WAKE_CAL_T) * EXT_CYC + 8, t1 - t0);
    u_host.shift(5, 5, 1'b0);
    power_down_n = 1'b0;
    repeat (3) @(negedge ref_clk_in);
    check_bit("pin power-down", 1'b1, ready_data_out);
    power_down_n = 1'b1;
    t0 = cycles;
    wait_fall(t1);
    check_time("restart", int'(CONV_HI) * EXT_CYC - 14, int'(CONV_HI) * EXT_CYC + 16, t1 - t0);
    read_value(24);
    rate_sel_in = 1'b0;
    wait_fall(t0);
    wait_fall(t1);
    check_time("low period", int'(CONV_LO) * EXT_CYC - 2, int'(CONV_LO) * EXT_CYC + 2, t1 - t0);
    end_of_test();
  end
endmodule : bsr_readout_tb
`default_nettype wire
